// ---- fsl_map.svh ----
/*
 * Constants for the flash security interlock: security word location,
 * key locations, field positions and reset values.
 * Assumes a 16-bit word-addressed program flash.
 */
`ifndef FSL_MAP_SVH
`define FSL_MAP_SVH

`define FSL_ADDR_W 16
`define FSL_DATA_W 16
`define FSL_SEC_ADDR 16'h7FF7
`define FSL_KEY_ADDR0 16'h7FFC
`define FSL_KEY_COUNT 4
`define FSL_SEC_BIT1 1
`define FSL_SEC_BIT0 0
`define FSL_ERASED_WORD 16'hFFFF

`endif

// ---- fsl_pkg.sv ----
/*
 * Types for the flash security interlock.
 * Assumes fsl_map.svh is on the include path.
 */
`include "fsl_map.svh"

package fsl_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [`FSL_ADDR_W-1:0] addr;
    logic [`FSL_DATA_W-1:0] wdata;
  } fsl_req_t;

  typedef enum logic [3:0] {
    FSL_ST_INIT = 4'b0001,
    FSL_ST_SAMPLE = 4'b0010,
    FSL_ST_WAIT = 4'b0100,
    FSL_ST_RUN = 4'b1000
  } fsl_state_t;
endpackage : fsl_pkg

// ---- fsl_flash_array.sv ----
/*
 * Program flash array model: reads are registered, a write programs
 * the addressed word by clearing bits only.
 * Assumes one request per cycle; contents start erased.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fsl_map.svh"

module fsl_flash_array
  import fsl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire fsl_req_t req,
  output logic [`FSL_DATA_W-1:0] rdata
);
  logic [`FSL_DATA_W-1:0] mem [0:(1<<15)-1];

  // -------------------------------------------------
  // programming: ones to zeroes only
  // -------------------------------------------------
  always_ff @(posedge clk) begin
    if (req.valid && req.write) begin
      mem[req.addr[14:0]] <= mem[req.addr[14:0]] & req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (req.valid && !req.write) begin
      rdata <= mem[req.addr[14:0]];
    end
  end

  initial begin
    for (int i = 0; i < (1<<15); i++) begin
      mem[i] = `FSL_ERASED_WORD;
    end
  end
endmodule : fsl_flash_array

`default_nettype wire

// ---- fsl_security_lock.sv ----
/*
 * Flash security interlock: holds the flash array, arbitrates core and
 * debug-port accesses, decides the secured state from the security word
 * at reset and runs the four-word back-door key compare.
 * Assumes core and debug requests are one-cycle pulses, synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fsl_map.svh"

module fsl_security_lock
  import fsl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire fsl_req_t core_req,
  output logic [`FSL_DATA_W-1:0] core_rdata,
  output logic core_rvalid,
  input wire logic key_unlock,
  input wire fsl_req_t dbg_req,
  output logic [`FSL_DATA_W-1:0] dbg_rdata,
  output logic dbg_rvalid,
  output logic dbg_refused,
  output logic secured,
  output logic init_done
);
  fsl_state_t state_reg;
  fsl_req_t arr_req;
  logic [`FSL_DATA_W-1:0] arr_rdata;
  logic [`FSL_DATA_W-1:0] sec_word_reg;
  logic [`FSL_DATA_W-1:0] key_words_reg [0:`FSL_KEY_COUNT-1];
  logic [`FSL_DATA_W-1:0] fetch_word;
  logic [2:0] fetch_idx_reg;
  logic [2:0] key_cnt_reg;
  logic key_match_reg;
  logic key_unlocked_reg;
  logic rd_core_reg;
  logic rd_dbg_reg;
  logic dbg_ok;
  logic dbg_take;
  logic core_take;
  logic key_access;

  // -------------------------------------------------
  // access arbitration: init fetch, core, then debug
  // -------------------------------------------------
  assign dbg_ok = (state_reg == FSL_ST_RUN) && !secured;
  assign core_take = (state_reg == FSL_ST_RUN) && core_req.valid;
  assign dbg_take = dbg_req.valid && dbg_ok && !core_req.valid;
  assign key_access = core_take && key_unlock;

  always_comb begin
    arr_req = '0;
    if (state_reg == FSL_ST_SAMPLE) begin
      arr_req.valid = 1'b1;
      arr_req.addr = (fetch_idx_reg == 3'd0) ? `FSL_SEC_ADDR :
        `FSL_KEY_ADDR0 + {13'h0000, fetch_idx_reg - 3'd1};
    end else if (core_take && !key_access) begin
      arr_req = core_req;
    end else if (dbg_take) begin
      arr_req = dbg_req;
    end
  end

  fsl_flash_array u_array (
    .clk(clk),
    .rst_n(rst_n),
    .req(arr_req),
    .rdata(arr_rdata)
  );

  // -------------------------------------------------
  // reset sampling of security word and key words
  // -------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= FSL_ST_INIT;
      fetch_idx_reg <= 3'd0;
    end else begin
      unique case (state_reg)
        FSL_ST_INIT: begin
          state_reg <= FSL_ST_SAMPLE;
        end
        FSL_ST_SAMPLE: begin
          state_reg <= FSL_ST_WAIT;
        end
        FSL_ST_WAIT: begin
          if (fetch_idx_reg == 3'(`FSL_KEY_COUNT)) begin
            state_reg <= FSL_ST_RUN;
          end else begin
            fetch_idx_reg <= fetch_idx_reg + 3'd1;
            state_reg <= FSL_ST_SAMPLE;
          end
        end
        FSL_ST_RUN: begin
          state_reg <= FSL_ST_RUN;
        end
      endcase
    end
  end

  assign fetch_word = arr_rdata;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_word_reg <= `FSL_ERASED_WORD;
    end else if (state_reg == FSL_ST_WAIT && fetch_idx_reg == 3'd0) begin
      sec_word_reg <= fetch_word;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `FSL_KEY_COUNT; g++) begin : g_key
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          key_words_reg[g] <= `FSL_ERASED_WORD;
        end else if (state_reg == FSL_ST_WAIT && fetch_idx_reg == 3'(g+1)) begin
          key_words_reg[g] <= fetch_word;
        end
      end
    end
  endgenerate

  // -------------------------------------------------
  // back-door key: four consecutive key accesses
  // -------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_cnt_reg <= 3'd0;
      key_match_reg <= 1'b1;
      key_unlocked_reg <= 1'b0;
    end else if (core_take) begin
      if (!key_access) begin
        key_cnt_reg <= 3'd0;
        key_match_reg <= 1'b1;
      end else if (key_cnt_reg == 3'(`FSL_KEY_COUNT-1)) begin
        key_cnt_reg <= 3'd0;
        key_match_reg <= 1'b1;
        if (key_match_reg &&
            core_req.wdata == key_words_reg[`FSL_KEY_COUNT-1]) begin
          key_unlocked_reg <= 1'b1;
        end
      end else begin
        key_cnt_reg <= key_cnt_reg + 3'd1;
        key_match_reg <= key_match_reg &&
          (core_req.wdata == key_words_reg[key_cnt_reg[1:0]]);
      end
    end
  end

  // secured from the sampled word, never rewritten by key unlock
  assign secured = (state_reg != FSL_ST_RUN) ||
    (sec_word_reg[`FSL_SEC_BIT1] && !sec_word_reg[`FSL_SEC_BIT0] &&
     !key_unlocked_reg);
  assign init_done = (state_reg == FSL_ST_RUN);
  assign dbg_refused = dbg_req.valid && !dbg_ok;

  // -------------------------------------------------
  // read returns
  // -------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_core_reg <= 1'b0;
      rd_dbg_reg <= 1'b0;
    end else begin
      rd_core_reg <= core_take && !key_access && !core_req.write;
      rd_dbg_reg <= dbg_take && !dbg_req.write;
    end
  end

  assign core_rvalid = rd_core_reg;
  assign core_rdata = arr_rdata;
  assign dbg_rvalid = rd_dbg_reg;
  assign dbg_rdata = rd_dbg_reg ? arr_rdata : '0;

  // -------------------------------------------------
  // checks
  // -------------------------------------------------
  secured_dbg_block_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (dbg_req.valid && secured) |-> (dbg_refused && !dbg_take)
      ##1 !dbg_rvalid)
    else $error("debug access passed while secured");

  secure_decode_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (init_done && !key_unlocked_reg) |->
      (secured == (sec_word_reg[1] && !sec_word_reg[0])))
    else $error("secured state disagrees with security word");

  key_unlock_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (key_access && key_cnt_reg == 3'd3 && key_match_reg &&
     core_req.wdata == key_words_reg[3]) |=> (key_unlocked_reg && !secured))
    else $error("matching key did not unsecure");

  key_interrupt_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (core_take && !key_access) |=> (key_cnt_reg == 3'd0))
    else $error("key sequence survived other flash access");

  sec_word_keep_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (init_done && $rose(key_unlocked_reg)) |-> $stable(sec_word_reg))
    else $error("key unlock altered security word");

  dbg_after_unlock_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (dbg_req.valid && !dbg_req.write && !secured && init_done &&
     !core_req.valid) |=> dbg_rvalid)
    else $error("debug read refused after unlock");

  init_before_dbg_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !init_done |-> (secured && !dbg_take))
    else $error("debug granted before security sampled");

  // last core read-back, so a later read of the same word can be compared
  logic [`FSL_ADDR_W-1:0] rd_addr_reg;
  logic [`FSL_ADDR_W-1:0] seen_addr_reg;
  logic [`FSL_DATA_W-1:0] seen_word_reg;
  logic seen_ok_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr_reg <= '0;
      seen_addr_reg <= '0;
      seen_word_reg <= '0;
      seen_ok_reg <= 1'b0;
    end else begin
      if (core_take && !key_access && !core_req.write) begin
        rd_addr_reg <= core_req.addr;
      end
      if (rd_core_reg) begin
        seen_addr_reg <= rd_addr_reg;
        seen_word_reg <= arr_rdata;
        seen_ok_reg <= 1'b1;
      end
    end
  end

  prog_clear_only_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (core_rvalid && seen_ok_reg && rd_addr_reg == seen_addr_reg) |->
      ((core_rdata & ~seen_word_reg) == '0))
    else $error("programming set a bit to one");
endmodule : fsl_security_lock

`default_nettype wire

// ---- fsl_dbg_host.sv ----
/*
 * Debug host model: issues one debug-port read at a time.
 * Assumes fsl_pkg is compiled first and clk is the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fsl_map.svh"

module fsl_dbg_host
  import fsl_pkg::*;
(
  input wire logic clk,
  output var fsl_req_t dbg_req,
  input wire logic [`FSL_DATA_W-1:0] dbg_rdata,
  input wire logic dbg_rvalid,
  input wire logic dbg_refused
);
  initial dbg_req = '0;

  // one-cycle request; released fields are scrambled, not held
  task automatic rd(input logic [15:0] a, output logic [15:0] d,
                    output logic ok, output logic rf);
    @(posedge clk);
    dbg_req <= '{valid: 1'b1, write: 1'b0, addr: a, wdata: 16'h0000};
    #1 rf = dbg_refused;
    @(posedge clk);
    dbg_req <= '{valid: 1'b0, write: 1'b0, addr: ~a, wdata: 16'hffff};
    #1 ok = dbg_rvalid;
    d = dbg_rdata;
  endtask : rd
endmodule : fsl_dbg_host
`default_nettype wire

// ---- tb_flash_security_lock.sv ----
/*
 * Self-checking bench for the flash security interlock.
 * Assumes fsl_pkg, the design and fsl_dbg_host are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fsl_map.svh"

module tb_flash_security_lock
  import fsl_pkg::*;
;
  logic clk, rst_n, key_unlock, core_rvalid, dbg_rvalid, dbg_refused;
  logic secured, init_done;
  fsl_req_t core_req, dbg_req;
  logic [15:0] core_rdata, dbg_rdata;
  int n_fail = 0;
  int checks_done = 0;
  logic [15:0] key [4] = '{16'ha5c3, 16'h1e0f, 16'h7788, 16'h0bad};

  fsl_security_lock u_fsl_security_lock (.clk(clk), .rst_n(rst_n),
    .core_req(core_req), .core_rdata(core_rdata),
    .core_rvalid(core_rvalid), .key_unlock(key_unlock),
    .dbg_req(dbg_req), .dbg_rdata(dbg_rdata), .dbg_rvalid(dbg_rvalid),
    .dbg_refused(dbg_refused), .secured(secured), .init_done(init_done));
  fsl_dbg_host u_fsl_dbg_host (.clk(clk), .dbg_req(dbg_req),
    .dbg_rdata(dbg_rdata), .dbg_rvalid(dbg_rvalid),
    .dbg_refused(dbg_refused));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("fails=%0d checks=%0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk16

  task automatic chk1(input logic g, input logic e);
    chk16({15'h0000, g}, {15'h0000, e});
  endtask : chk1

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    #1 chk1(secured, 1'b1);
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 50 && init_done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (init_done !== 1'b1) begin
      n_fail++;
      final_report();
    end
  endtask : do_reset

  task automatic acc(input logic w, input logic k, input logic [15:0] a,
                     input logic [15:0] d);
    @(posedge clk);
    core_req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    key_unlock <= k;
    @(posedge clk);
    core_req <= '{valid: 1'b0, write: 1'b0, addr: ~a, wdata: ~d};
    key_unlock <= 1'b0;
    #1;
  endtask : acc

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    acc(1'b0, 1'b0, a, 16'h0000);
    chk1(core_rvalid, 1'b1);
    chk16(core_rdata, e);
  endtask : rd_chk

  task automatic dbg_chk(input logic [15:0] a, input logic [15:0] e,
                         input logic grant);
    logic [15:0] d;
    logic ok, rf;
    u_fsl_dbg_host.rd(a, d, ok, rf);
    chk1(rf, ~grant);
    chk1(ok, grant);
    if (grant) begin
      chk16(d, e);
    end else begin
      chk16(d, 16'h0000);
    end
  endtask : dbg_chk

  // brk puts a plain read between key words 1 and 2
  task automatic send_key(input logic [15:0] bad, input logic brk);
    for (int i = 0; i < 4; i++) begin
      if (brk && i == 2) acc(1'b0, 1'b0, 16'h0010, 16'h0000);
      acc(1'b0, 1'b1, `FSL_KEY_ADDR0 + 16'(i),
          key[i] ^ ((i == 3) ? bad : 16'h0000));
    end
    @(posedge clk);
    #1;
  endtask : send_key

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic sc_program();
    do_reset();
    chk1(secured, 1'b0);
    dbg_chk(16'h0010, 16'hffff, 1'b1);
    acc(1'b1, 1'b0, 16'h0010, 16'h1234);
    rd_chk(16'h0010, 16'h1234);
    acc(1'b1, 1'b0, 16'h0010, 16'hffff);
    rd_chk(16'h0010, 16'h1234);
    acc(1'b1, 1'b0, 16'h0010, 16'h00f0);
    rd_chk(16'h0010, 16'h0030);
  endtask : sc_program

  task automatic sc_secure();
    for (int i = 0; i < 4; i++) acc(1'b1, 1'b0, `FSL_KEY_ADDR0 + 16'(i), key[i]);
    acc(1'b1, 1'b0, `FSL_SEC_ADDR, 16'hfffe);
    chk1(secured, 1'b0);
    do_reset();
    chk1(secured, 1'b1);
    dbg_chk(16'h0010, 16'h0000, 1'b0);
  endtask : sc_secure

  task automatic sc_key();
    send_key(16'h0001, 1'b0);
    chk1(secured, 1'b1);
    send_key(16'h0000, 1'b1);
    chk1(secured, 1'b1);
    // a plain access drops the two key words left over after the break
    rd_chk(16'h0010, 16'h0030);
    send_key(16'h0000, 1'b0);
    chk1(secured, 1'b0);
    dbg_chk(16'h0010, 16'h0030, 1'b1);
    rd_chk(`FSL_SEC_ADDR, 16'hfffe);
    do_reset();
    chk1(secured, 1'b1);
  endtask : sc_key

  task automatic sc_clear();
    acc(1'b1, 1'b0, `FSL_SEC_ADDR, 16'h0000);
    do_reset();
    chk1(secured, 1'b0);
    dbg_chk(`FSL_SEC_ADDR, 16'h0000, 1'b1);
  endtask : sc_clear

  initial begin
    rst_n = 1'b0;
    key_unlock = 1'b0;
    core_req = '0;
    sc_program();
    sc_secure();
    sc_key();
    sc_clear();
    final_report();
  end
endmodule : tb_flash_security_lock
`default_nettype wire
